// >>> tb_tcu_top.sv
`timescale 1ns/1ps
`include "tcu_defs.svh"
module tb_tcu_top;
  logic        clk, rst, cyc, stb, we, ack, irq, t1m, t2m;
  logic [7:0]  adr, t1c, t2c;
  logic [31:0] wdat, rdat, q;
  logic [4:0]  pins;
  int          mismatches, checks_done, cycles, t1m_cnt;

  tcu_top u_tcu_top (
    .CORE_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .IRQ(irq), .BASE_CLK_PIN(pins[0]), .SHARED_CLK_PIN(pins[1]),
    .CAP_TIMER_CLK_PIN(pins[2]), .CAPTURE_ONE_PIN(pins[3]),
    .CAPTURE_TWO_PIN(pins[4]), .T1_COUNT(t1c), .T2_COUNT(t2c),
    .T1_MATCH(t1m), .T2_MATCH(t2m)
  );
  tcu_pin_model u_pin (.clk(clk), .pins(pins));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  // run is about 11k cycles
  always @(posedge clk) begin
    cycles++;
    if (t1m === 1'b1)
      t1m_cnt++;
    if (cycles == 40000) begin
      mismatches++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // held until ack is sampled, released at that edge
  task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d);
  endtask : wr

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    check(q, {24'h0, exp});
  endtask : rd_chk

  task automatic t_regs;
    rd_chk(`TCU_IDX_BTC, 8'h00);
    rd_chk(`TCU_IDX_TCC, 8'h00);
    wr(6'h3f, 8'h55);
    rd_chk(6'h3f, 8'h00);
    wr(`TCU_IDX_BTC, 8'hff);
    rd_chk(`TCU_IDX_BTC, 8'hfe);
    wr(`TCU_IDX_BTC, 8'h00);
    wr(`TCU_IDX_BASE_H, 8'h12);
    rd_chk(`TCU_IDX_BASE_H, 8'h12);
  endtask : t_regs

  task automatic t_base;
    for (int c = 0; c < 9; c++) begin
      // code 8 stands for every 1xxx pattern
      wr(`TCU_IDX_BTC, 8'(c << 1));
      wr(`TCU_IDX_BASE_L, 8'h00);
      wr(`TCU_IDX_BASE_H, 8'h00);
      u_pin.pulse(0, 2 << c);
      rd_chk(`TCU_IDX_BASE_L, 8'h02);
    end
    // rising pin edges, then a short burst on the internal clock
    wr(`TCU_IDX_BTC, 8'h40);
    wr(`TCU_IDX_BASE_L, 8'h00);
    u_pin.pulse(0, 2);
    rd_chk(`TCU_IDX_BASE_L, 8'h02);
    wr(`TCU_IDX_BTC, 8'h20);
    wr(`TCU_IDX_BTC, 8'h00);
    wb(1'b0, `TCU_IDX_BASE_L, 8'h00);
    check(32'(q[7:0] > 8'h02), 32'h1);
    rd_chk(`TCU_IDX_BASE_L, q[7:0]);
  endtask : t_base

  task automatic t_eight;
    int m0;
    wr(`TCU_IDX_TCC, 8'h01);
    wr(`TCU_IDX_PR1, 8'h03);
    wr(`TCU_IDX_T1, 8'h00);
    wr(`TCU_IDX_IST, 8'h02);
    u_pin.pulse(1, 3);
    rd_chk(`TCU_IDX_T1, 8'h03);
    check(t1c, 32'h3);
    // second timer on internal clock with period zero wraps every cycle
    check(t2c, 32'h0);
    check(t2m, 32'h1);
    wb(1'b0, `TCU_IDX_IST, 8'h00);
    check(q[1], 32'h0);
    m0 = t1m_cnt;
    u_pin.pulse(1, 1);
    rd_chk(`TCU_IDX_T1, 8'h00);
    check(t1m_cnt - m0, 32'h1);
    wb(1'b0, `TCU_IDX_IST, 8'h00);
    check(q[1], 32'h1);
    wr(`TCU_IDX_IMASK, 8'h02);
    check(irq, 32'h1);
    wr(`TCU_IDX_IST, 8'h02);
    check(irq, 32'h0);
    wr(`TCU_IDX_IMASK, 8'h00);
  endtask : t_eight

  task automatic t_chain;
    wr(`TCU_IDX_PR1, 8'hff);
    wr(`TCU_IDX_PR2, 8'hff);
    wr(`TCU_IDX_TCC, 8'h09);
    wr(`TCU_IDX_T1, 8'hff);
    wr(`TCU_IDX_T2, 8'h00);
    u_pin.pulse(1, 1);
    rd_chk(`TCU_IDX_T1, 8'h00);
    rd_chk(`TCU_IDX_T2, 8'h01);
  endtask : t_chain

  task automatic t_capture;
    logic [7:0] v;
    // period mode first: pin clocked, wraps after the period value
    wr(`TCU_IDX_TCC, 8'h04);
    wr(`TCU_IDX_PC1_L, 8'h02);
    wr(`TCU_IDX_T3_L, 8'h00);
    wr(`TCU_IDX_IST, 8'h08);
    u_pin.pulse(2, 3);
    rd_chk(`TCU_IDX_T3_L, 8'h00);
    wb(1'b0, `TCU_IDX_IST, 8'h00);
    check(q[3], 32'h1);
    wr(`TCU_IDX_CAPCFG, 8'h01);
    for (int ch = 0; ch < 2; ch++) begin
      for (int m = 0; m < 4; m++) begin
        v = 8'(ch * 16 + m + 1);
        // external capture clock with its pin idle keeps the timer frozen
        wr(`TCU_IDX_TCC, 8'h04 | 8'(m << (ch ? 6 : 4)));
        wr(`TCU_IDX_T3_L, v);
        wr(`TCU_IDX_T3_H, 8'ha5);
        rd_chk(`TCU_IDX_T3_L, v);
        wr(`TCU_IDX_IST, 8'h30);
        if (m < 2) begin
          u_pin.drive(3 + ch, 1'b0);
          wb(1'b0, `TCU_IDX_IST, 8'h00);
          check(q[4 + ch], 32'(m == 0));
          u_pin.drive(3 + ch, 1'b1);
        end else begin
          u_pin.pulse(3 + ch, m == 2 ? 4 : 16);
        end
        wb(1'b0, `TCU_IDX_IST, 8'h00);
        check(q[4 + ch], 32'h1);
        rd_chk(ch ? `TCU_IDX_CA2_L : `TCU_IDX_PC1_L, v);
        rd_chk(ch ? `TCU_IDX_CA2_H : `TCU_IDX_PC1_H, 8'ha5);
      end
    end
  endtask : t_capture

  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_base();
    t_eight();
    t_chain();
    t_capture();
    results();
  end
endmodule : tb_tcu_top

// >>> tcu_defs.svh
`ifndef TCU_DEFS_SVH
`define TCU_DEFS_SVH

// register word indices, byte address is index * 4
`define TCU_IDX_BASE_L   6'h00
`define TCU_IDX_BASE_H   6'h01
`define TCU_IDX_T1       6'h02
`define TCU_IDX_T2       6'h03
`define TCU_IDX_PR1      6'h04
`define TCU_IDX_BTC      6'h05
`define TCU_IDX_PR2      6'h06
`define TCU_IDX_T3_L     6'h07
`define TCU_IDX_T3_H     6'h08
`define TCU_IDX_PC1_L    6'h09
`define TCU_IDX_PC1_H    6'h0a
`define TCU_IDX_CA2_L    6'h0b
`define TCU_IDX_CA2_H    6'h0c
`define TCU_IDX_IST      6'h0d
`define TCU_IDX_IMASK    6'h0e
`define TCU_IDX_CAPCFG   6'h0f
`define TCU_IDX_TCC      6'h16

// base_timer_control fields
`define TCU_BTC_SE       6
`define TCU_BTC_CS       5
`define TCU_BTC_PS_HI    4
`define TCU_BTC_WMASK    8'hfe
`define TCU_BTC_RST      8'h00

// timer_capture_control fields
`define TCU_TCC_CS1      0
`define TCU_TCC_CS2      1
`define TCU_TCC_CS3      2
`define TCU_TCC_CHAIN    3
`define TCU_TCC_RST      8'h00

// interrupt status bits
`define TCU_IRQ_BASE     0
`define TCU_IRQ_T1       1
`define TCU_IRQ_T2       2
`define TCU_IRQ_T3       3
`define TCU_IRQ_CA1      4
`define TCU_IRQ_CA2      5

// pin positions in the synchroniser vectors
`define TCU_PIN_BASE     0
`define TCU_PIN_SHARED   1
`define TCU_PIN_T3       2
`define TCU_PIN_CA1      3
`define TCU_PIN_IDLE     5'h1f

`define TCU_PRE_FULL     8'hff

`endif

// >>> tcu_pin_model.sv
`timescale 1ns/1ps
module tcu_pin_model (
  input  wire logic       clk,
  output logic      [4:0] pins
);
  // idle high as if pulled up; each level held long enough to pass the filter
  initial pins = 5'h1f;

  task automatic drive(input int idx, input logic v);
    @(posedge clk);
    pins[idx] <= v;
    repeat (4) @(posedge clk);
  endtask : drive

  task automatic pulse(input int idx, input int n);
    for (int i = 0; i < n; i++) begin
      drive(idx, 1'b0);
      drive(idx, 1'b1);
    end
  endtask : pulse
endmodule : tcu_pin_model

// >>> tcu_pkg.sv
package tcu_pkg;

  typedef enum logic [1:0] {
    CAP_FALL,
    CAP_RISE,
    CAP_RISE4,
    CAP_RISE16
  } tcu_cap_mode_t;

  typedef struct packed {
    logic [4:0]      s0;
    logic [4:0]      s1;
    logic [4:0]      s2;
    logic [4:0]      flt;
    logic [7:0]      btc;
    logic [7:0]      tcc;
    logic            cap_cfg;
    logic [7:0]      pre;
    logic [15:0]     t0;
    logic [7:0]      t1;
    logic [7:0]      t2;
    logic [7:0]      pr1;
    logic [7:0]      pr2;
    logic [15:0]     t3;
    logic [15:0]     pc1;
    logic [15:0]     ca2;
    logic [1:0][3:0] div;
    logic [5:0]      ist;
    logic [5:0]      imask;
    logic            ack;
    logic [7:0]      dat;
    logic            t1m;
    logic            t2m;
  } tcu_state_t;

endpackage : tcu_pkg

// >>> tcu_top.sv
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`include "tcu_defs.svh"

// Overview of operation
// - base timer is 16 bits, byte accessible
// - 8-bit prescaler, ratios 1 to 256
// - base source bit: internal or pin
// - two 8-bit timers, periods and flags
// - internal clock or shared pin falling edges
// - chain bit joins timers into 16 bits
// - per-timer clock select bits 0 and 1
// - capture timer clock select, own pin
// - capture timer 16 bits, two bytes
// - one pair is period or capture one
// - second pair holds only capture two
// - captures latch capture timer on event
// - capture two mode field selects trigger
// - capture one uses same trigger encoding
// - 8-bit timers give pwm time base
module tcu_top #(
  parameter int CAP_CHANNELS = 2
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             IRQ,
  input  wire logic        BASE_CLK_PIN,
  input  wire logic        SHARED_CLK_PIN,
  input  wire logic        CAP_TIMER_CLK_PIN,
  input  wire logic        CAPTURE_ONE_PIN,
  input  wire logic        CAPTURE_TWO_PIN,
  output logic      [7:0]  T1_COUNT,
  output logic      [7:0]  T2_COUNT,
  output logic             T1_MATCH,
  output logic             T2_MATCH
);
  import tcu_pkg::*;

  // the register map only has room for two capture channels
  if (CAP_CHANNELS != 2) begin : g_bad_channels
    $error("capture channel count must be two");
  end

  tcu_state_t  r;
  tcu_state_t  n;
  logic [5:0]  idx;
  logic        req;
  logic        wr_en;
  logic [7:0]  wdat;
  logic [7:0]  rdata;
  logic [4:0]  upd;
  logic [4:0]  rise;
  logic [4:0]  fall;
  logic [7:0]  pre_lim;
  logic        base_tick;
  logic        tick1;
  logic        tick2;
  logic        tick3;
  logic [1:0]  cap_evt;
  logic [1:0][3:0] div_n;
  logic [5:0]  ist_set;
  logic [5:0]  ist_clr;

  assign idx   = WB_ADR_I[7:2];
  assign req   = WB_CYC_I && WB_STB_I && !r.ack;
  assign wr_en = req && WB_WE_I && WB_SEL_I[0];
  assign wdat  = WB_DAT_I[7:0];

  // a change counts only once stages two and three agree
  assign upd  = ~(r.s1 ^ r.s2) & (r.s1 ^ r.flt);
  assign rise = upd & r.s1;
  assign fall = upd & ~r.s1;

  // codes 1xxx all give the longest ratio
  assign pre_lim = r.btc[`TCU_BTC_PS_HI] ? `TCU_PRE_FULL :
                   (8'h01 << r.btc[3:1]) - 8'h01;
  assign base_tick = r.btc[`TCU_BTC_CS] ? 1'b1 :
                     (r.btc[`TCU_BTC_SE] ? rise[`TCU_PIN_BASE]
                                         : fall[`TCU_PIN_BASE]);
  assign tick1 = r.tcc[`TCU_TCC_CS1] ? fall[`TCU_PIN_SHARED] : 1'b1;
  assign tick2 = r.tcc[`TCU_TCC_CS2] ? fall[`TCU_PIN_SHARED] : 1'b1;
  assign tick3 = r.tcc[`TCU_TCC_CS3] ? fall[`TCU_PIN_T3] : 1'b1;

  // capture trigger qualification, one instance per channel
  generate
    for (genvar i = 0; i < CAP_CHANNELS; i++) begin : g_cap
      logic          evt;
      logic [3:0]    dv;
      tcu_cap_mode_t mode;
      logic          rs;
      logic          fl;
      always_comb begin
        mode = tcu_cap_mode_t'(r.tcc[4 + 2 * i +: 2]);
        rs   = rise[`TCU_PIN_CA1 + i];
        fl   = fall[`TCU_PIN_CA1 + i];
        dv   = rs ? r.div[i] + 4'h1 : r.div[i];
        case (mode)
          CAP_FALL:   evt = fl;
          CAP_RISE:   evt = rs;
          CAP_RISE4:  evt = rs && (r.div[i][1:0] == 2'h3);
          CAP_RISE16: evt = rs && (r.div[i] == 4'hf);
          default:    evt = 1'b0;
        endcase
      end
      assign cap_evt[i] = evt;
      assign div_n[i]   = dv;
    end
  endgenerate

  always_comb begin
    case (idx)
      `TCU_IDX_BASE_L: rdata = r.t0[7:0];
      `TCU_IDX_BASE_H: rdata = r.t0[15:8];
      `TCU_IDX_T1:     rdata = r.t1;
      `TCU_IDX_T2:     rdata = r.t2;
      `TCU_IDX_PR1:    rdata = r.pr1;
      `TCU_IDX_BTC:    rdata = r.btc & `TCU_BTC_WMASK;
      `TCU_IDX_PR2:    rdata = r.pr2;
      `TCU_IDX_T3_L:   rdata = r.t3[7:0];
      `TCU_IDX_T3_H:   rdata = r.t3[15:8];
      `TCU_IDX_PC1_L:  rdata = r.pc1[7:0];
      `TCU_IDX_PC1_H:  rdata = r.pc1[15:8];
      `TCU_IDX_CA2_L:  rdata = r.ca2[7:0];
      `TCU_IDX_CA2_H:  rdata = r.ca2[15:8];
      `TCU_IDX_IST:    rdata = {2'h0, r.ist};
      `TCU_IDX_IMASK:  rdata = {2'h0, r.imask};
      `TCU_IDX_CAPCFG: rdata = {7'h00, r.cap_cfg};
      `TCU_IDX_TCC:    rdata = r.tcc;
      default:         rdata = 8'h00;
    endcase
  end

  always_comb begin
    n       = r;
    ist_set = 6'h00;
    ist_clr = 6'h00;
    n.s0  = {CAPTURE_TWO_PIN, CAPTURE_ONE_PIN, CAP_TIMER_CLK_PIN,
             SHARED_CLK_PIN, BASE_CLK_PIN};
    n.s1  = r.s0;
    n.s2  = r.s1;
    n.flt = (r.flt & ~upd) | (r.s1 & upd);
    n.ack = req;
    if (req && !WB_WE_I) begin
      n.dat = rdata;
    end
    n.t1m = 1'b0;
    n.t2m = 1'b0;

    if (base_tick) begin
      if (r.pre >= pre_lim) begin
        n.pre = 8'h00;
        n.t0  = r.t0 + 16'h1;
        if (r.t0 == 16'hffff) begin
          ist_set[`TCU_IRQ_BASE] = 1'b1;
        end
      end else begin
        n.pre = r.pre + 8'h1;
      end
    end

    if (r.tcc[`TCU_TCC_CHAIN]) begin
      // chained pair runs on the first timer's clock select
      if (tick1) begin
        if ({r.t2, r.t1} == {r.pr2, r.pr1}) begin
          n.t1  = 8'h00;
          n.t2  = 8'h00;
          n.t1m = 1'b1;
          ist_set[`TCU_IRQ_T1] = 1'b1;
        end else begin
          {n.t2, n.t1} = {r.t2, r.t1} + 16'h1;
        end
      end
    end else begin
      if (tick1) begin
        if (r.t1 == r.pr1) begin
          n.t1  = 8'h00;
          n.t1m = 1'b1;
          ist_set[`TCU_IRQ_T1] = 1'b1;
        end else begin
          n.t1 = r.t1 + 8'h1;
        end
      end
      if (tick2) begin
        if (r.t2 == r.pr2) begin
          n.t2  = 8'h00;
          n.t2m = 1'b1;
          ist_set[`TCU_IRQ_T2] = 1'b1;
        end else begin
          n.t2 = r.t2 + 8'h1;
        end
      end
    end

    if (tick3) begin
      if (!r.cap_cfg && r.t3 == r.pc1) begin
        n.t3 = 16'h0000;
        ist_set[`TCU_IRQ_T3] = 1'b1;
      end else begin
        n.t3 = r.t3 + 16'h1;
        if (r.t3 == 16'hffff) begin
          ist_set[`TCU_IRQ_T3] = 1'b1;
        end
      end
    end

    // software writes win over counting
    if (wr_en) begin
      case (idx)
        `TCU_IDX_BASE_L: n.t0[7:0]  = wdat;
        `TCU_IDX_BASE_H: n.t0[15:8] = wdat;
        `TCU_IDX_T1:     n.t1       = wdat;
        `TCU_IDX_T2:     n.t2       = wdat;
        `TCU_IDX_PR1:    n.pr1      = wdat;
        `TCU_IDX_BTC:    n.btc      = wdat & `TCU_BTC_WMASK;
        `TCU_IDX_PR2:    n.pr2      = wdat;
        `TCU_IDX_T3_L:   n.t3[7:0]  = wdat;
        `TCU_IDX_T3_H:   n.t3[15:8] = wdat;
        `TCU_IDX_PC1_L:  n.pc1[7:0] = wdat;
        `TCU_IDX_PC1_H:  n.pc1[15:8] = wdat;
        `TCU_IDX_CA2_L:  n.ca2[7:0] = wdat;
        `TCU_IDX_CA2_H:  n.ca2[15:8] = wdat;
        `TCU_IDX_IST:    ist_clr    = wdat[5:0];
        `TCU_IDX_IMASK:  n.imask    = wdat[5:0];
        `TCU_IDX_CAPCFG: n.cap_cfg  = wdat[0];
        `TCU_IDX_TCC:    n.tcc      = wdat;
        default:         n.pre      = n.pre;
      endcase
    end

    // a hardware capture beats a same-cycle software write
    n.div = div_n;
    if (r.cap_cfg && cap_evt[0]) begin
      n.pc1 = r.t3;
      ist_set[`TCU_IRQ_CA1] = 1'b1;
    end
    if (cap_evt[1]) begin
      n.ca2 = r.t3;
      ist_set[`TCU_IRQ_CA2] = 1'b1;
    end
    n.ist = (r.ist & ~ist_clr) | ist_set;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      r     <= '0;
      r.btc <= `TCU_BTC_RST;
      r.tcc <= `TCU_TCC_RST;
      // pins idle high, so leaving reset shows no false edge
      r.s0  <= `TCU_PIN_IDLE;
      r.s1  <= `TCU_PIN_IDLE;
      r.s2  <= `TCU_PIN_IDLE;
      r.flt <= `TCU_PIN_IDLE;
    end else begin
      r <= n;
    end
  end

  assign WB_DAT_O = {24'h000000, r.dat};
  assign WB_ACK_O = r.ack;
  assign IRQ      = |(r.ist & r.imask);
  assign T1_COUNT = r.t1;
  assign T2_COUNT = r.t2;
  assign T1_MATCH = r.t1m;
  assign T2_MATCH = r.t2m;

  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  logic wr_t0;
  logic wr_t12;
  logic wr_t3;
  logic wr_ca2;
  logic wr_pc1;
  assign wr_t0  = wr_en && (idx == `TCU_IDX_BASE_L || idx == `TCU_IDX_BASE_H);
  assign wr_t12 = wr_en && (idx == `TCU_IDX_T1 || idx == `TCU_IDX_T2);
  assign wr_t3  = wr_en && (idx == `TCU_IDX_T3_L || idx == `TCU_IDX_T3_H);
  assign wr_ca2 = wr_en && (idx == `TCU_IDX_CA2_L || idx == `TCU_IDX_CA2_H);
  assign wr_pc1 = wr_en && (idx == `TCU_IDX_PC1_L || idx == `TCU_IDX_PC1_H);

  sequence s_wb_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_wb_ack;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence

  a_wb_ack_once: assert property (s_wb_req |=> s_wb_ack)
    else $error("bus ack not a single cycle after request");

  a_base_low_wr: assert property (
    (wr_en && idx == `TCU_IDX_BASE_L) |=> r.t0[7:0] == $past(WB_DAT_I[7:0]))
    else $error("base low byte write lost");

  a_pre_div1: assert property (
    (r.btc[`TCU_BTC_CS] && r.btc[4:1] == 4'h0 && !wr_t0)
      |=> r.t0 == $past(r.t0) + 16'h1)
    else $error("base timer not counting at ratio one");

  a_base_pin_idle: assert property (
    (!r.btc[`TCU_BTC_CS] && !upd[`TCU_PIN_BASE] && !wr_t0) |=> $stable(r.t0))
    else $error("base timer moved without pin edge");

  a_t1_wrap: assert property (
    (!r.tcc[`TCU_TCC_CHAIN] && tick1 && r.t1 == r.pr1 && !wr_t12)
      |=> (r.t1 == 8'h00) && r.ist[`TCU_IRQ_T1] && T1_MATCH)
    else $error("first timer did not wrap on period");

  a_t1_count: assert property (
    (!r.tcc[`TCU_TCC_CHAIN] && !r.tcc[`TCU_TCC_CS1] && r.t1 != r.pr1 && !wr_t12)
      |=> r.t1 == $past(r.t1) + 8'h1)
    else $error("first timer missed internal tick");

  a_chain_carry: assert property (
    (r.tcc[`TCU_TCC_CHAIN] && tick1 && r.t1 == 8'hff && !wr_t12
      && {r.t2, r.t1} != {r.pr2, r.pr1})
      |=> r.t1 == 8'h00 && r.t2 == $past(r.t2) + 8'h1)
    else $error("chained carry missing");

  a_t3_pin_idle: assert property (
    (r.tcc[`TCU_TCC_CS3] && !fall[`TCU_PIN_T3] && !wr_t3) |=> $stable(r.t3))
    else $error("capture timer moved without pin edge");

  a_cap2_latch: assert property (
    cap_evt[1] |=> r.ca2 == $past(r.t3) && r.ist[`TCU_IRQ_CA2])
    else $error("capture two did not latch");

  a_cap2_div4: assert property (
    (r.tcc[7:6] == 2'h2 && rise[`TCU_PIN_CA1 + 1] && r.div[1][1:0] != 2'h3 && !wr_ca2)
      |=> $stable(r.ca2))
    else $error("capture two fired early in divide mode");

  a_set_wins: assert property (
    (cap_evt[1] && wr_en && idx == `TCU_IDX_IST && WB_DAT_I[5]) |=> r.ist[5])
    else $error("status clear beat a new event");

  a_t1_pin_idle: assert property (
    (!r.tcc[`TCU_TCC_CHAIN] && r.tcc[`TCU_TCC_CS1] && !fall[`TCU_PIN_SHARED] && !wr_t12)
      |=> $stable(r.t1))
    else $error("first timer moved without pin edge");

  a_t2_wrap: assert property (
    (!r.tcc[`TCU_TCC_CHAIN] && tick2 && r.t2 == r.pr2 && !wr_t12)
      |=> (r.t2 == 8'h00) && r.ist[`TCU_IRQ_T2] && T2_MATCH)
    else $error("second timer did not wrap on period");

  a_chain_hold: assert property (
    (r.tcc[`TCU_TCC_CHAIN] && !tick1 && !wr_t12) |=> $stable({r.t2, r.t1}))
    else $error("chained timer moved without tick");

  a_t3_period: assert property (
    (!r.cap_cfg && tick3 && r.t3 == r.pc1 && !wr_t3) |=> r.t3 == 16'h0000)
    else $error("capture timer did not wrap on period");

  a_pc1_period: assert property (
    (!r.cap_cfg && !wr_pc1) |=> $stable(r.pc1))
    else $error("period register changed in period mode");

  a_cap1_latch: assert property (
    (r.cap_cfg && cap_evt[0]) |=> r.pc1 == $past(r.t3) && r.ist[`TCU_IRQ_CA1])
    else $error("capture one did not latch");

  a_ca2_hold: assert property (
    (!cap_evt[1] && !wr_ca2) |=> $stable(r.ca2))
    else $error("capture two changed without event");

  a_pin_once: assert property (
    upd[`TCU_PIN_SHARED] |=> !upd[`TCU_PIN_SHARED])
    else $error("pin edge counted twice");

endmodule : tcu_top
